// [core/lois_pkg.sv]
// Constants, codes and register map of the link and online status block.
// Contract
// RULE1: P2P master link on; off after 3x timeout.
// RULE2: P2P online off unlinked, green once linked.
// RULE3: Severed P2P flashes online red per drop.
// RULE4: P2P link red forces online off.
// RULE5: Broadcast/SCADA master link green on data, 3x timeout.
// RULE6: Broadcast/SCADA online green on data, short off.
// RULE7: Dial-up online off unconnected, green connected.
// RULE8: Dial-up master link on; off after 3x.
// RULE9: Dialler flashes red per drop; link red, online off.
// RULE10: Called unit online off on first missed poll.
// RULE11: Slave link on while locked; off after 2x.
// RULE12: DCD/CTS high while followed indicator lit.
// RULE13: Link timeout and poll interval configure timers.
package lois_pkg;
    // Clock rate and the length of one millisecond in cycles.
    localparam int CLK_MHZ = 125;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / 1000 * CLK_MHZ;

    // Hold multipliers of the network link timeout.
    localparam logic [1:0] MASTER_MULT = 2'h3;
    localparam logic [1:0] SLAVE_MULT = 2'h2;
    // Online hold after data in broadcast and SCADA modes, in ms.
    localparam logic [17:0] SHORT_MS = 18'h001F4;
    localparam int TMR_W = 18;

    typedef enum logic [1:0] {
        MODE_P2P = 2'h0,
        MODE_BCAST = 2'h1,
        MODE_DIAL = 2'h2,
        MODE_SCADA = 2'h3
    } lois_mode_t;

    typedef enum logic [1:0] {
        IND_OFF = 2'h0,
        IND_RED = 2'h1,
        IND_GREEN = 2'h2
    } lois_ind_t;

    typedef enum logic [1:0] {
        FOL_HIGH = 2'h0,
        FOL_ONLINE = 2'h1,
        FOL_LINK = 2'h2,
        FOL_LOW = 2'h3
    } lois_fol_t;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LTO = 8'h04;
    localparam logic [7:0] ADDR_POLL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_ISTAT = 8'h10;
    localparam logic [7:0] ADDR_IMASK = 8'h14;

    // Control fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MASTER_BIT = 2;
    localparam int CTRL_DCD_LSB = 4;
    localparam int CTRL_CTS_LSB = 6;

    // Status fields.
    localparam int STAT_LINK_LSB = 0;
    localparam int STAT_ONL_LSB = 2;
    localparam int STAT_CONN_BIT = 4;

    // Interrupt bits.
    localparam int INT_W = 4;
    localparam int INT_LINK = 0;
    localparam int INT_ONL = 1;
    localparam int INT_DROP = 2;
    localparam int INT_MISS = 3;

    // Reset values.
    localparam logic [15:0] LTO_RST = 16'h01F4;
    localparam logic [15:0] POLL_RST = 16'h0BB8;
endpackage

// [core/lois_ms_timer.sv]
// Millisecond down-counter used for indicator hold and flash times.
`timescale 1ns/1ps
module lois_ms_timer #(
    parameter int W = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_r;

    // A load of zero cancels a running count without a done pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (tick && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign busy = cnt_r != '0;
    assign done = !load && tick && cnt_r == {{(W-1){1'b0}}, 1'b1};
endmodule

// [core/lois_link_status.sv]
// Network link and online indicator logic with its APB register file.
`timescale 1ns/1ps
module lois_link_status #(
    parameter int MS_CYCLES = lois_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conn_up,
    input wire logic conn_down,
    input wire logic rx_data,
    input wire logic master_rx,
    input wire logic locked,
    input wire logic pkt_drop,
    input wire logic poll_miss,
    input wire logic originator,
    output logic [1:0] link_ind,
    output logic [1:0] online_ind,
    output logic dcd,
    output logic cts,
    output logic irq
);
    localparam int MSC_W = $clog2(MS_CYCLES);
    localparam int TW = lois_pkg::TMR_W;

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Multiple of the link timeout in ms, never below one.
    function automatic logic [TW-1:0] hold_ms(input logic [15:0] ms, input logic [1:0] k);
        logic [TW-1:0] v;
        v = TW'(ms) * TW'(k);
        return (v == '0) ? {{(TW-1){1'b0}}, 1'b1} : v;
    endfunction

    // Level of a handshake output for its follow selection.
    function automatic logic follow(input lois_pkg::lois_fol_t sel,
                                    input lois_pkg::lois_ind_t lk,
                                    input lois_pkg::lois_ind_t on);
        logic v;
        v = 1'b1;
        unique case (sel)
            lois_pkg::FOL_HIGH: v = 1'b1;
            lois_pkg::FOL_ONLINE: v = on != lois_pkg::IND_OFF;
            lois_pkg::FOL_LINK: v = lk != lois_pkg::IND_OFF;
            lois_pkg::FOL_LOW: v = 1'b0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    lois_pkg::lois_mode_t mode_r;
    logic master_r;
    lois_pkg::lois_fol_t dcd_sel_r;
    lois_pkg::lois_fol_t cts_sel_r;
    logic [15:0] lto_r;
    logic [15:0] poll_r;
    logic [lois_pkg::INT_W-1:0] istat_r;
    logic [lois_pkg::INT_W-1:0] imask_r;
    logic [31:0] prdata_r;
    lois_pkg::lois_ind_t link_r;
    lois_pkg::lois_ind_t link_nxt;
    lois_pkg::lois_ind_t onl_r;
    lois_pkg::lois_ind_t onl_nxt;
    logic conn_r;
    logic conn_nxt;
    logic miss_r;
    logic miss_nxt;
    logic dcd_r;
    logic cts_r;
    logic [MSC_W-1:0] msc_r;
    logic ms_tick;
    logic lt_load;
    logic [TW-1:0] lt_val;
    logic lt_done;
    logic ot_load;
    logic [TW-1:0] ot_val;
    logic ot_busy;
    logic ot_done;
    logic conn_mode;
    logic flash_start;
    logic miss_set;
    logic wr_en;
    logic addr_ok;
    logic [lois_pkg::INT_W-1:0] ev;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave. Zero wait states; read data is captured in the setup cycle.

    assign wr_en = psel && penable && pwrite;
    assign addr_ok = paddr == lois_pkg::ADDR_CTRL || paddr == lois_pkg::ADDR_LTO ||
                     paddr == lois_pkg::ADDR_POLL || paddr == lois_pkg::ADDR_STAT ||
                     paddr == lois_pkg::ADDR_ISTAT || paddr == lois_pkg::ADDR_IMASK;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= lois_pkg::MODE_P2P;
            master_r <= 1'b0;
            dcd_sel_r <= lois_pkg::FOL_HIGH;
            cts_sel_r <= lois_pkg::FOL_HIGH;
            lto_r <= lois_pkg::LTO_RST;
            poll_r <= lois_pkg::POLL_RST;
            imask_r <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                lois_pkg::ADDR_CTRL: begin
                    mode_r <= lois_pkg::lois_mode_t'(pwdata[lois_pkg::CTRL_MODE_LSB +: 2]);
                    master_r <= pwdata[lois_pkg::CTRL_MASTER_BIT];
                    dcd_sel_r <= lois_pkg::lois_fol_t'(pwdata[lois_pkg::CTRL_DCD_LSB +: 2]);
                    cts_sel_r <= lois_pkg::lois_fol_t'(pwdata[lois_pkg::CTRL_CTS_LSB +: 2]);
                end
                lois_pkg::ADDR_LTO: lto_r <= pwdata[15:0]; // see RULE13
                lois_pkg::ADDR_POLL: poll_r <= pwdata[15:0]; // see RULE13
                lois_pkg::ADDR_IMASK: imask_r <= pwdata[lois_pkg::INT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= '0;
            unique case (paddr)
                lois_pkg::ADDR_CTRL: begin
                    prdata_r[lois_pkg::CTRL_MODE_LSB +: 2] <= mode_r;
                    prdata_r[lois_pkg::CTRL_MASTER_BIT] <= master_r;
                    prdata_r[lois_pkg::CTRL_DCD_LSB +: 2] <= dcd_sel_r;
                    prdata_r[lois_pkg::CTRL_CTS_LSB +: 2] <= cts_sel_r;
                end
                lois_pkg::ADDR_LTO: prdata_r[15:0] <= lto_r;
                lois_pkg::ADDR_POLL: prdata_r[15:0] <= poll_r;
                lois_pkg::ADDR_STAT: begin
                    prdata_r[lois_pkg::STAT_LINK_LSB +: 2] <= link_r;
                    prdata_r[lois_pkg::STAT_ONL_LSB +: 2] <= onl_r;
                    prdata_r[lois_pkg::STAT_CONN_BIT] <= conn_r;
                end
                lois_pkg::ADDR_ISTAT: prdata_r[lois_pkg::INT_W-1:0] <= istat_r;
                lois_pkg::ADDR_IMASK: prdata_r[lois_pkg::INT_W-1:0] <= imask_r;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and the two hold timers.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msc_r <= '0;
        end else if (msc_r == MSC_W'(MS_CYCLES - 1)) begin
            msc_r <= '0;
        end else begin
            msc_r <= msc_r + 1'b1;
        end
    end
    assign ms_tick = msc_r == MSC_W'(MS_CYCLES - 1);

    lois_ms_timer #(.W(TW)) u_link_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tick(ms_tick),
        .load(lt_load),
        .load_val(lt_val),
        .busy(),
        .done(lt_done)
    );

    lois_ms_timer #(.W(TW)) u_onl_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tick(ms_tick),
        .load(ot_load),
        .load_val(ot_val),
        .busy(ot_busy),
        .done(ot_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Connection tracking. A connect in the same cycle as a close wins.

    assign conn_mode = mode_r == lois_pkg::MODE_P2P || mode_r == lois_pkg::MODE_DIAL;
    assign conn_nxt = conn_up || (conn_r && !conn_down);
    assign miss_set = conn_mode && mode_r == lois_pkg::MODE_DIAL && !originator &&
                      conn_r && poll_miss;
    assign miss_nxt = !conn_up && (miss_set || miss_r);
    assign flash_start = conn_mode && conn_r && !conn_down && !conn_up && !miss_r && pkt_drop &&
                         (mode_r == lois_pkg::MODE_P2P || originator);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conn_r <= 1'b0;
            miss_r <= 1'b0;
        end else begin
            conn_r <= conn_nxt;
            miss_r <= miss_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Network link indicator.

    always_comb begin
        link_nxt = link_r;
        lt_load = 1'b0;
        lt_val = '0;
        if (!master_r) begin
            if (!locked) begin
                link_nxt = lois_pkg::IND_OFF; // see RULE11
                lt_load = 1'b1;
            end else if (master_rx) begin
                link_nxt = lois_pkg::IND_GREEN; // see RULE11
                lt_load = 1'b1;
                lt_val = hold_ms(lto_r, lois_pkg::SLAVE_MULT); // see RULE13
            end else if (lt_done) begin
                link_nxt = lois_pkg::IND_OFF; // see RULE11
            end
        end else if (conn_mode) begin
            if (conn_up) begin
                link_nxt = lois_pkg::IND_GREEN; // see RULE1 see RULE8
                lt_load = 1'b1;
            end else if (conn_down && link_r == lois_pkg::IND_GREEN) begin
                link_nxt = lois_pkg::IND_RED; // see RULE1 see RULE8
                lt_load = 1'b1;
                lt_val = hold_ms(lto_r, lois_pkg::MASTER_MULT);
            end else if (lt_done) begin
                link_nxt = lois_pkg::IND_OFF; // see RULE1 see RULE8
            end
        end else begin
            if (rx_data) begin
                link_nxt = lois_pkg::IND_GREEN; // see RULE5
                lt_load = 1'b1;
                lt_val = hold_ms(lto_r, lois_pkg::MASTER_MULT);
            end else if (lt_done) begin
                link_nxt = lois_pkg::IND_OFF; // see RULE5
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_r <= lois_pkg::IND_OFF;
        end else begin
            link_r <= link_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Online indicator. A red flash lasts half a poll interval.

    always_comb begin
        onl_nxt = onl_r;
        ot_load = 1'b0;
        ot_val = '0;
        if (conn_mode) begin
            if (link_nxt == lois_pkg::IND_RED && master_r) begin
                onl_nxt = lois_pkg::IND_OFF; // see RULE4 see RULE9
                ot_load = 1'b1;
            end else if (conn_up) begin
                onl_nxt = lois_pkg::IND_GREEN; // see RULE2 see RULE7
                ot_load = 1'b1;
            end else if (conn_down) begin
                onl_nxt = lois_pkg::IND_OFF; // see RULE2 see RULE7
                ot_load = 1'b1;
            end else if (miss_set) begin
                onl_nxt = lois_pkg::IND_OFF; // see RULE10
                ot_load = 1'b1;
            end else if (flash_start) begin
                onl_nxt = lois_pkg::IND_RED; // see RULE3 see RULE9
                ot_load = 1'b1;
                ot_val = (poll_r[15:1] == '0) ? TW'(1) : TW'(poll_r[15:1]); // see RULE13
            end else if (ot_done && onl_r == lois_pkg::IND_RED) begin
                onl_nxt = lois_pkg::IND_GREEN; // see RULE3
            end
        end else begin
            if (rx_data) begin
                onl_nxt = lois_pkg::IND_GREEN; // see RULE6
                ot_load = 1'b1;
                ot_val = lois_pkg::SHORT_MS;
            end else if (ot_done) begin
                onl_nxt = lois_pkg::IND_OFF; // see RULE6
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            onl_r <= lois_pkg::IND_OFF;
        end else begin
            onl_r <= onl_nxt;
        end
    end

    assign link_ind = link_r;
    assign online_ind = onl_r;

    ////////////////////////////////////////////////////////////////////////////
    // Serial handshake outputs.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcd_r <= 1'b1;
            cts_r <= 1'b1;
        end else begin
            dcd_r <= follow(dcd_sel_r, link_nxt, onl_nxt); // see RULE12
            cts_r <= follow(cts_sel_r, link_nxt, onl_nxt); // see RULE12
        end
    end
    assign dcd = dcd_r;
    assign cts = cts_r;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts. A new event wins over a write-one-to-clear.

    always_comb begin
        ev = '0;
        ev[lois_pkg::INT_LINK] = link_nxt != link_r;
        ev[lois_pkg::INT_ONL] = onl_nxt != onl_r;
        ev[lois_pkg::INT_DROP] = flash_start;
        ev[lois_pkg::INT_MISS] = miss_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_r <= '0;
        end else if (wr_en && paddr == lois_pkg::ADDR_ISTAT) begin
            istat_r <= (istat_r & ~pwdata[lois_pkg::INT_W-1:0]) | ev;
        end else begin
            istat_r <= istat_r | ev;
        end
    end
    assign irq = |(istat_r & imask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    link_up_green_a: assert property ( // see RULE1
        master_r && conn_mode && conn_up |=> link_r == lois_pkg::IND_GREEN)
        else $error("link not green after connect");

    link_close_red_a: assert property ( // see RULE8
        master_r && conn_mode && !conn_up && conn_down && link_r == lois_pkg::IND_GREEN
        |=> link_r == lois_pkg::IND_RED ##1 link_r == lois_pkg::IND_RED)
        else $error("link not held after close");

    onl_conn_green_a: assert property ( // see RULE2
        conn_mode && conn_up |=> onl_r == lois_pkg::IND_GREEN)
        else $error("online not green after connect");

    onl_flash_red_a: assert property ( // see RULE3
        flash_start && !(master_r && link_nxt == lois_pkg::IND_RED)
        |=> onl_r == lois_pkg::IND_RED)
        else $error("online did not flash red");

    red_link_off_a: assert property ( // see RULE4
        conn_mode && master_r && link_r == lois_pkg::IND_RED |-> onl_r == lois_pkg::IND_OFF)
        else $error("online lit while link red");

    bcast_rx_green_a: assert property ( // see RULE5
        !conn_mode && master_r && rx_data
        |=> link_r == lois_pkg::IND_GREEN && onl_r == lois_pkg::IND_GREEN)
        else $error("data did not light indicators");

    miss_onl_off_a: assert property ( // see RULE10
        miss_set && !conn_up |=> onl_r == lois_pkg::IND_OFF)
        else $error("online lit after missed poll");

    slave_unlock_off_a: assert property ( // see RULE11
        !master_r && !locked |=> link_r == lois_pkg::IND_OFF)
        else $error("slave link lit while unlocked");

    dcd_follow_a: assert property ( // see RULE12
        $stable(dcd_sel_r) && dcd_sel_r == lois_pkg::FOL_LINK
        |-> dcd == (link_r != lois_pkg::IND_OFF))
        else $error("dcd does not follow link");

    flash_cover_c: cover property (flash_start ##1 onl_r == lois_pkg::IND_RED);
    hold_cover_c: cover property (link_r == lois_pkg::IND_RED ##1 link_r == lois_pkg::IND_OFF);
    bcast_cover_c: cover property (!conn_mode && ot_busy ##1 ot_done);
    irq_cover_c: cover property ($rose(irq));
endmodule

// [verification/lois_remote.sv]
// Behavioural model of the remote modem that raises link events.
`timescale 1ns/1ps
module lois_remote (
    input wire logic pclk,
    output logic conn_up,
    output logic conn_down,
    output logic rx_data,
    output logic master_rx,
    output logic locked,
    output logic pkt_drop,
    output logic poll_miss,
    output logic originator
);
    logic [5:0] ev_r = 6'h00;
    initial begin
        locked = 1'b0;
        originator = 1'b0;
    end
    assign {poll_miss, pkt_drop, master_rx, rx_data, conn_down, conn_up} = ev_r;
    ////////////////////////////////////////////////////////////////////////
    // Each event is one clock wide, as a real link layer would report it.
    task automatic pulse(input int code);
        @(posedge pclk);
        ev_r <= 6'h01 << code;
        @(posedge pclk);
        ev_r <= 6'h00;
    endtask
    task automatic set_level(input logic lk, input logic org);
        @(posedge pclk);
        locked <= lk;
        originator <= org;
    endtask
endmodule

// [verification/lois_link_status_tb.sv]
// Self-checking bench for the link and online status block.
`timescale 1ns/1ps
module lois_link_status_tb;
    localparam int MSC = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, conn_up, conn_down, rx_data, master_rx;
    logic locked, pkt_drop, poll_miss, originator, dcd, cts, irq;
    logic [1:0] link_ind, online_ind;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int total_checks = 0;
    always #4 pclk = ~pclk;
    lois_link_status #(.MS_CYCLES(MSC)) i_lois_link_status (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conn_up(conn_up),
        .conn_down(conn_down), .rx_data(rx_data), .master_rx(master_rx), .locked(locked),
        .pkt_drop(pkt_drop), .poll_miss(poll_miss), .originator(originator),
        .link_ind(link_ind), .online_ind(online_ind), .dcd(dcd), .cts(cts), .irq(irq));
    lois_remote i_lois_remote (.pclk(pclk), .conn_up(conn_up), .conn_down(conn_down),
        .rx_data(rx_data), .master_rx(master_rx), .locked(locked), .pkt_drop(pkt_drop),
        .poll_miss(poll_miss), .originator(originator));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %0h expected %0h", $time, msg, got, exp);
        end
    endtask
    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t bus transfer never answered", $time);
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge pclk);
    endtask
    function automatic logic [31:0] ind(input int sel);
        return sel ? {30'h0, online_ind} : {30'h0, link_ind};
    endfunction
    // A hold of N ms ends between N-1 and N ms after its event.
    task automatic hold(input int sel, input logic [31:0] val, input int ms);
        tick((ms - 1) * MSC - 3);
        chk(ind(sel), val, "held indicator");
        tick(MSC + 6);
        chk(ind(sel), 32'h0, "indicator expired");
    endtask
    task automatic ev(input int code);
        i_lois_remote.pulse(code);
        tick(1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        rdchk(lois_pkg::ADDR_LTO, {16'h0, lois_pkg::LTO_RST}, "lto reset");
        rdchk(lois_pkg::ADDR_POLL, {16'h0, lois_pkg::POLL_RST}, "poll reset");
        chk({30'h0, dcd, cts}, 32'h3, "handshake reset");
        wr(lois_pkg::ADDR_CTRL, 32'hF0);
        tick(2);
        chk({30'h0, dcd, cts}, 32'h0, "handshake forced low");
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        wr(lois_pkg::ADDR_STAT, 32'h1F);
        rdchk(lois_pkg::ADDR_STAT, 32'h0, "status read only");
        wr(lois_pkg::ADDR_LTO, 32'h4);
        wr(lois_pkg::ADDR_POLL, 32'h8);
        rdchk(lois_pkg::ADDR_LTO, 32'h4, "lto written");
        $display("test regs done");
    endtask
    task automatic test_p2p();
        wr(lois_pkg::ADDR_CTRL, 32'h64);
        ev(0);
        chk(ind(0), 32'h2, "p2p link on");
        chk(ind(1), 32'h2, "p2p online on");
        chk({30'h0, dcd, cts}, 32'h3, "follow lit");
        rdchk(lois_pkg::ADDR_STAT, 32'h1A, "status connected");
        ev(4);
        chk(ind(1), 32'h1, "drop flash");
        tick(5 * MSC + 3);
        chk(ind(1), 32'h2, "flash over");
        ev(1);
        chk(ind(0), 32'h1, "link red on close");
        chk(ind(1), 32'h0, "online off");
        chk({30'h0, dcd, cts}, 32'h2, "dcd on cts off");
        hold(0, 32'h1, 12);
        chk({30'h0, dcd, cts}, 32'h0, "follow dark");
        $display("test p2p done");
    endtask
    task automatic test_bcast();
        for (int i = 0; i < 2; i++) begin
            wr(lois_pkg::ADDR_CTRL, i ? 32'h7 : 32'h5);
            ev(2);
            chk(ind(0), 32'h2, "data link");
            chk(ind(1), 32'h2, "data online");
            hold(0, 32'h2, 12);
            chk(ind(1), 32'h2, "online still on");
            tick(500 * MSC);
            chk(ind(1), 32'h0, "online quiet off");
        end
        $display("test broadcast done");
    endtask
    task automatic test_dial();
        i_lois_remote.set_level(1'b0, 1'b1);
        wr(lois_pkg::ADDR_CTRL, 32'h6);
        chk(ind(1), 32'h0, "dial idle");
        ev(0);
        chk(ind(0), 32'h2, "dial link");
        chk(ind(1), 32'h2, "dial online");
        ev(4);
        chk(ind(1), 32'h1, "dialler flash");
        tick(5 * MSC + 3);
        ev(1);
        chk(ind(0), 32'h1, "dial link red");
        chk(ind(1), 32'h0, "dial online off");
        hold(0, 32'h1, 12);
        i_lois_remote.set_level(1'b0, 1'b0);
        wr(lois_pkg::ADDR_CTRL, 32'h2);
        ev(0);
        ev(4);
        chk(ind(1), 32'h2, "called no flash");
        ev(5);
        chk(ind(1), 32'h0, "called miss off");
        apb(1'b0, lois_pkg::ADDR_ISTAT, 32'h0);
        chk(rd & 32'hC, 32'hC, "drop and miss flagged");
        ev(1);
        $display("test dial done");
    endtask
    task automatic test_slave();
        wr(lois_pkg::ADDR_CTRL, 32'h0);
        i_lois_remote.set_level(1'b1, 1'b0);
        ev(3);
        chk(ind(0), 32'h2, "slave link");
        hold(0, 32'h2, 8);
        ev(3);
        i_lois_remote.set_level(1'b0, 1'b0);
        tick(2);
        chk(ind(0), 32'h0, "unlock off");
        $display("test slave done");
    endtask
    task automatic test_irq();
        wr(lois_pkg::ADDR_ISTAT, 32'hF);
        wr(lois_pkg::ADDR_IMASK, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h0, "irq clear");
        i_lois_remote.set_level(1'b1, 1'b0);
        ev(3);
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b0, lois_pkg::ADDR_ISTAT, 32'h0);
        chk(rd, 32'h1, "only link event bit");
        wr(lois_pkg::ADDR_IMASK, 32'h0);
        tick(1);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(lois_pkg::ADDR_IMASK, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(lois_pkg::ADDR_ISTAT, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test irq done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_p2p();
        test_bcast();
        test_dial();
        test_slave();
        test_irq();
        end_of_test();
    end
endmodule
